// >>> dttu_pkg.sv
`default_nettype none
// Shared constants of the debug trigger and trace unit.
package dttu_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port.
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_TRIG_BASE = 8'h40;
    localparam logic [3:0] TRIG_OFS_ADDR = 4'h0;
    localparam logic [3:0] TRIG_OFS_DATA = 4'h4;
    localparam logic [3:0] TRIG_OFS_CFG  = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register fields.
    localparam int CTRL_START     = 0;
    localparam int CTRL_STOP      = 1;
    localparam int CTRL_STOP_FULL = 2;
    localparam int CTRL_EXEC_EN   = 3;
    localparam int CTRL_MODE_LSB  = 4;
    localparam int CTRL_DISARM    = 8;
    localparam int CTRL_RELEASE   = 9;
    localparam int MODE_W         = 3;

    // Status register fields.
    localparam int ST_TRACE_ON  = 0;
    localparam int ST_ARMED     = 1;
    localparam int ST_BREAK     = 2;
    localparam int ST_FULL      = 3;
    localparam int ST_COUNT_LSB = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger configuration fields: conditions, then actions.
    localparam int CFG_EN       = 0;
    localparam int CFG_BUS      = 1;
    localparam int CFG_ADDR     = 2;
    localparam int CFG_DATA     = 3;
    localparam int CFG_RD       = 4;
    localparam int CFG_WR       = 5;
    localparam int CFG_ARMED    = 6;
    localparam int CFG_RANGE    = 7;
    localparam int CFG_ACT_BRK  = 8;
    localparam int CFG_ACT_EXT  = 9;
    localparam int CFG_ACT_TON  = 10;
    localparam int CFG_ACT_TOFF = 11;
    localparam int CFG_ACT_SAMP = 12;
    localparam int CFG_ACT_ARM  = 13;
    localparam int CFG_W        = 14;

    ////////////////////////////////////////////////////////////////////////////////
    // Data trace filter modes and trace frame kinds.
    typedef enum logic [MODE_W-1:0] {
        MODE_LD_A, MODE_ST_A, MODE_BOTH_A, MODE_LD_D,
        MODE_LD_AD, MODE_ST_AD, MODE_BOTH_AD, MODE_SAMPLE
    } dttu_mode_t;

    typedef enum logic [1:0] {KIND_NONE, KIND_EXEC, KIND_LOAD, KIND_STORE} dttu_kind_t;

    // Reset values of the stored control fields.
    localparam logic       RST_STOP_FULL = 1'b0;
    localparam logic       RST_EXEC_EN   = 1'b1;
    localparam dttu_mode_t RST_MODE      = MODE_BOTH_AD;

endpackage : dttu_pkg
`default_nettype wire

// >>> dttu_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Instruction address breakpoint hands processor to debug
// - Match one address on either bus
// - Match one data value on data bus
// - Qualify data match on read or write
// - Conditions on one trigger are ANDed
// - Armed condition matches only after arming event
// - Arm action enables dependent second trigger
// - Paired triggers bound an address/data range on the data bus
// - Break action halts processor, debug takes control
// - External trigger action pulses trigger output
// - Trace on/off actions start/stop capture
// - Sample action stores one data bus sample
// - Host starts and stops trace manually
// - Optional stop capture when buffer full
// - Trace buffer readable only over JTAG
// - Execution trace stores flow changes, compressed
// - Data trace filter selects one of eight modes
// - Requested data transfers are recorded; a full buffer drops the oldest frames or, with stop on full, the new ones
// - Execution frames written before data frames
module dttu_top
    import dttu_pkg::*;
#(
    parameter int NTRIG = 4,
    parameter int DEPTH = 16
)(
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RST,
    // Register port.
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // Processor instruction bus.
    input  wire logic        I_VALID,
    input  wire logic [31:0] I_ADDR,
    input  wire logic        I_FLOW,
    // Processor data bus.
    input  wire logic        D_VALID,
    input  wire logic        D_WRITE,
    input  wire logic [31:0] D_ADDR,
    input  wire logic [31:0] D_DATA,
    // Debug actions.
    output logic             BREAK_REQ,
    output logic             EXT_TRIG,
    // JTAG trace readout.
    input  wire logic        JTAG_TCK,
    input  wire logic        JTAG_SHIFT,
    output logic             JTAG_TDO
);

    // Pointer width from the buffer depth; a frame is kind, address and data.
    localparam int AW = $clog2(DEPTH);
    localparam int FW = 66;

    // Everything the unit remembers lives in one registered word.
    typedef struct packed {
        logic [NTRIG-1:0][31:0]      t_addr;
        logic [NTRIG-1:0][31:0]      t_data;
        logic [NTRIG-1:0][CFG_W-1:0] t_cfg;
        logic                        stop_full;
        logic                        exec_en;
        dttu_mode_t                  mode;
        logic                        trace_on;
        logic                        armed;
        logic                        brk;
        logic                        ext;
        logic [15:0]                 icnt;
        logic [DEPTH-1:0][FW-1:0]    mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
        logic [FW-1:0]               shreg;
        logic                        tck_s1;
        logic                        tck_s2;
        logic                        tck_s3;
        logic                        sh_s1;
        logic                        sh_s2;
        logic                        sh_s3;
        logic [31:0]                 rdata;
    } dttu_state_t;

    // Present state and the value it takes at the next clock edge.
    dttu_state_t r_r;
    dttu_state_t r_nxt;

    // Action requests of each trigger, merged further down.
    logic [NTRIG-1:0] brk_v;
    logic [NTRIG-1:0] ext_v;
    logic [NTRIG-1:0] ton_v;
    logic [NTRIG-1:0] toff_v;
    logic [NTRIG-1:0] samp_v;
    logic [NTRIG-1:0] arm_v;

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger comparators, one per trigger.
    for (genvar i = 0; i < NTRIG; i++)
    begin : g_trig
        localparam int NX = (i + 1) % NTRIG;
        logic [CFG_W-1:0] c;
        logic             on_bus;
        logic             rng;
        logic [31:0]      a;
        logic             a_ok;
        logic             d_ok;
        logic             rw_ok;
        logic             hit;

        // The bus chosen by the trigger is only looked at while it carries a transfer.
        assign c      = r_r.t_cfg[i];
        assign on_bus = c[CFG_BUS] ? D_VALID : I_VALID;
        assign a      = c[CFG_BUS] ? D_ADDR : I_ADDR;
        assign rng    = c[CFG_RANGE] & c[CFG_BUS];
        // Bounds come from this trigger and the next one when a range is selected on the data bus.
        assign a_ok   = !c[CFG_ADDR] || (rng ? (a >= r_r.t_addr[i] && a <= r_r.t_addr[NX])
                                             : a == r_r.t_addr[i]);
        assign d_ok   = !c[CFG_DATA] || !c[CFG_BUS]
                        || (rng ? (D_DATA >= r_r.t_data[i] && D_DATA <= r_r.t_data[NX])
                                : D_DATA == r_r.t_data[i]);
        // Read-only and write-only together never match a data bus transfer.
        assign rw_ok  = !c[CFG_BUS] || ((!c[CFG_RD] || !D_WRITE) && (!c[CFG_WR] || D_WRITE));
        // All enabled conditions must hold together.
        assign hit    = c[CFG_EN] & on_bus & a_ok & d_ok & rw_ok
                        & (!c[CFG_ARMED] || r_r.armed);
        // A matching trigger raises each of its enabled actions; sample only on the data bus.
        assign brk_v[i]  = hit & c[CFG_ACT_BRK];
        assign ext_v[i]  = hit & c[CFG_ACT_EXT];
        assign ton_v[i]  = hit & c[CFG_ACT_TON];
        assign toff_v[i] = hit & c[CFG_ACT_TOFF];
        assign samp_v[i] = hit & c[CFG_ACT_SAMP] & c[CFG_BUS];
        assign arm_v[i]  = hit & c[CFG_ACT_ARM];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state signals.
    // Decode results and frame assembly used inside the next-state process.
    logic          ctrl_wr;
    logic [7:0]    toff;
    logic [3:0]    tidx;
    logic          trig_sel;
    logic          ld_a;
    logic          st_a;
    logic          ld_d;
    logic          st_d;
    logic          want_a;
    logic          want_d;
    logic          samp;
    logic          exec_v;
    logic          data_v;
    logic [FW-1:0] exec_f;
    logic [FW-1:0] data_f;
    logic          tck_rise;
    logic          sh_rise;
    logic          pop;
    logic [1:0]    n_req;
    logic [1:0]    n_wr;
    logic [1:0]    drop;
    logic [AW+1:0] free;
    logic [31:0]   st;

    // One pass computes every next value of the state.
    always_comb
    begin
        r_nxt    = r_r;
        // Register port address decode, shared by writes and reads.
        ctrl_wr  = REG_WR && REG_ADDR == OFS_CTRL;
        toff     = REG_ADDR - OFS_TRIG_BASE;
        tidx     = toff[7:4];
        trig_sel = REG_ADDR >= OFS_TRIG_BASE && tidx < 4'(NTRIG);

        // Two flip-flops on each JTAG pin, a third for edge finding.
        // The link clock must stay well below the system clock to be seen.
        r_nxt.tck_s1 = JTAG_TCK;
        r_nxt.tck_s2 = r_r.tck_s1;
        r_nxt.tck_s3 = r_r.tck_s2;
        // The readout select goes through the same two-stage synchroniser.
        r_nxt.sh_s1  = JTAG_SHIFT;
        r_nxt.sh_s2  = r_r.sh_s1;
        r_nxt.sh_s3  = r_r.sh_s2;
        tck_rise     = r_r.tck_s2 & ~r_r.tck_s3;
        sh_rise      = r_r.sh_s2 & ~r_r.sh_s3;

        // Register writes from the host.
        if (ctrl_wr)
        begin
            r_nxt.stop_full = REG_WDATA[CTRL_STOP_FULL];
            r_nxt.exec_en   = REG_WDATA[CTRL_EXEC_EN];
            r_nxt.mode      = dttu_mode_t'(REG_WDATA[CTRL_MODE_LSB +: MODE_W]);
        end
        if (REG_WR && trig_sel)
        begin
            unique case (toff[3:0])
                TRIG_OFS_ADDR: r_nxt.t_addr[tidx] = REG_WDATA;
                TRIG_OFS_DATA: r_nxt.t_data[tidx] = REG_WDATA;
                TRIG_OFS_CFG:  r_nxt.t_cfg[tidx]  = REG_WDATA[CFG_W-1:0];
                default: ;
            endcase
        end

        // Sticky action state; a new event wins over a clear in the same cycle.
        // The external trigger is a pulse of one cycle per matching transfer.
        r_nxt.ext   = |ext_v;
        r_nxt.armed = (|arm_v) | (r_r.armed & ~(ctrl_wr & REG_WDATA[CTRL_DISARM]));
        r_nxt.brk   = (|brk_v) | (r_r.brk & ~(ctrl_wr & REG_WDATA[CTRL_RELEASE]));

        // Data trace filter decode.
        ld_a   = r_r.mode inside {MODE_LD_A, MODE_BOTH_A, MODE_LD_AD, MODE_BOTH_AD};
        st_a   = r_r.mode inside {MODE_ST_A, MODE_BOTH_A, MODE_ST_AD, MODE_BOTH_AD};
        ld_d   = r_r.mode inside {MODE_LD_D, MODE_LD_AD, MODE_BOTH_AD};
        st_d   = r_r.mode inside {MODE_ST_AD, MODE_BOTH_AD};
        // Pick the filter half that matches the direction of the transfer.
        want_a = D_WRITE ? st_a : ld_a;
        want_d = D_WRITE ? st_d : ld_d;
        samp   = |samp_v;

        // Execution frame carries the flow-change address and instructions covered.
        exec_v = r_r.exec_en & r_r.trace_on & I_VALID & I_FLOW;
        exec_f = {KIND_EXEC, I_ADDR, 16'h0000, r_r.icnt + 16'h0001};
        // A sample is taken even while trace is off, and keeps all fields.
        data_v = samp | (r_r.trace_on & D_VALID & (want_a | want_d));
        data_f = {D_WRITE ? KIND_STORE : KIND_LOAD,
                  (samp | want_a) ? D_ADDR : 32'h0000_0000,
                  (samp | want_d) ? D_DATA : 32'h0000_0000};
        // Count the instructions since the last flow change for compression.
        if (r_r.exec_en & r_r.trace_on & I_VALID)
        begin
            r_nxt.icnt = I_FLOW ? 16'h0000 : r_r.icnt + 16'h0001;
        end

        // Buffer bookkeeping: readout pop, new frames, overflow handling.
        pop   = sh_rise & (r_r.count != '0);
        n_req = {1'b0, exec_v} + {1'b0, data_v};
        free  = (AW+2)'(DEPTH) - {1'b0, r_r.count} + {{(AW+1){1'b0}}, pop};
        // Without stop on full the oldest frames give way to new ones.
        n_wr  = n_req;
        drop  = 2'b00;
        if ({{AW{1'b0}}, n_req} > free)
        begin
            if (r_r.stop_full)
            begin
                n_wr = free[1:0];
            end
            else
            begin
                drop = n_req - free[1:0];
            end
        end
        // Execution frame takes the first slot, data frame the next.
        if (n_wr != 2'b00)
        begin
            r_nxt.mem[r_r.wptr] = exec_v ? exec_f : data_f;
        end
        if (n_wr == 2'b10)
        begin
            r_nxt.mem[r_r.wptr + AW'(1)] = data_f;
        end
        // Pointers wrap on their own because the depth is a power of two.
        r_nxt.wptr  = r_r.wptr + AW'(n_wr);
        r_nxt.rptr  = r_r.rptr + AW'(pop) + AW'(drop);
        r_nxt.count = r_r.count - (AW+1)'(pop) + (AW+1)'(n_wr) - (AW+1)'(drop);

        // Trace enable: manual and trigger starts win over any stop.
        // With stop on full, capture ends by itself once the buffer is full.
        r_nxt.trace_on = (|ton_v) | (ctrl_wr & REG_WDATA[CTRL_START])
                         | (r_r.trace_on & ~((|toff_v) | (ctrl_wr & REG_WDATA[CTRL_STOP])
                         | (r_r.stop_full & r_nxt.count == (AW+1)'(DEPTH))));

        // JTAG shift register: load oldest frame, then shift one bit per TCK.
        if (sh_rise)
        begin
            // An empty buffer hands out an all-zero frame of kind none.
            r_nxt.shreg = pop ? r_r.mem[r_r.rptr] : '0;
        end
        else if (tck_rise & r_r.sh_s2)
        begin
            r_nxt.shreg = r_r.shreg >> 1;
        end

        // Register read answers in the next cycle only.
        // Status shows live flags and the number of frames waiting.
        st                 = '0;
        st[ST_TRACE_ON]    = r_r.trace_on;
        st[ST_ARMED]       = r_r.armed;
        st[ST_BREAK]       = r_r.brk;
        st[ST_FULL]        = r_r.count == (AW+1)'(DEPTH);
        st[ST_COUNT_LSB +: AW+1] = r_r.count;
        r_nxt.rdata        = '0;
        if (REG_RD)
        begin
            if (REG_ADDR == OFS_CTRL)
            begin
                // Pulse bits read back as zero; only stored fields show.
                r_nxt.rdata[CTRL_STOP_FULL]              = r_r.stop_full;
                r_nxt.rdata[CTRL_EXEC_EN]                = r_r.exec_en;
                r_nxt.rdata[CTRL_MODE_LSB +: MODE_W]     = r_r.mode;
            end
            else if (REG_ADDR == OFS_STATUS)
            begin
                r_nxt.rdata = st;
            end
            else if (trig_sel)
            begin
                unique case (toff[3:0])
                    TRIG_OFS_ADDR: r_nxt.rdata = r_r.t_addr[tidx];
                    TRIG_OFS_DATA: r_nxt.rdata = r_r.t_data[tidx];
                    TRIG_OFS_CFG:  r_nxt.rdata[CFG_W-1:0] = r_r.t_cfg[tidx];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            // Control defaults come back; every other field clears.
            r_r           <= '0;
            r_r.stop_full <= RST_STOP_FULL;
            r_r.exec_en   <= RST_EXEC_EN;
            r_r.mode      <= RST_MODE;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // Outputs straight from flip-flops.
    // Read data is zero outside the cycle after a read strobe.
    assign REG_RDATA = r_r.rdata;
    assign BREAK_REQ = r_r.brk;
    assign EXT_TRIG  = r_r.ext;
    assign JTAG_TDO  = r_r.shreg[0];

endmodule : dttu_top
`default_nettype wire

// >>> dttu_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module dttu_props
    import dttu_pkg::*;
(
    // Clock and reset.
    input wire logic        MCLK,
    input wire logic        RST,
    // Register port.
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    // Buses, actions and readout.
    input wire logic        I_VALID,
    input wire logic        D_VALID,
    input wire logic        BREAK_REQ,
    input wire logic        EXT_TRIG,
    input wire logic        JTAG_SHIFT,
    input wire logic        JTAG_TDO
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    ////////////////////////////////////////
    // A release write to the control register.
    sequence s_release;
        REG_WR && REG_ADDR == OFS_CTRL && REG_WDATA[CTRL_RELEASE];
    endsequence
    // Readout select held low long enough to flush its synchroniser.
    sequence s_quiet;
        !JTAG_SHIFT [*6];
    endsequence

    property p_ext_idle;
        !I_VALID && !D_VALID |=> !EXT_TRIG;
    endproperty
    property p_brk_idle;
        !I_VALID && !D_VALID && !BREAK_REQ |=> !BREAK_REQ;
    endproperty
    property p_brk_hold;
        BREAK_REQ && !REG_WR |=> BREAK_REQ;
    endproperty
    property p_brk_release;
        s_release ##0 (!I_VALID && !D_VALID) |=> !BREAK_REQ;
    endproperty
    property p_rd_quiet;
        !REG_RD |=> REG_RDATA == 32'h0000_0000;
    endproperty
    property p_tdo_quiet;
        s_quiet |=> $stable(JTAG_TDO);
    endproperty
    property p_status_brk;
        REG_RD && REG_ADDR == OFS_STATUS |=> REG_RDATA[ST_BREAK] == $past(BREAK_REQ);
    endproperty
    property p_unmapped;
        REG_RD && REG_ADDR == 8'hFC |=> REG_RDATA == 32'h0000_0000;
    endproperty

    a_ext_idle: assert property (p_ext_idle)
        else $error("External trigger without a bus transfer");
    a_brk_idle: assert property (p_brk_idle)
        else $error("Break raised without a bus transfer");
    a_brk_hold: assert property (p_brk_hold)
        else $error("Break request dropped without a release");
    a_brk_release: assert property (p_brk_release)
        else $error("Break request kept after a release");
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("Read data not zero outside a read");
    a_tdo_quiet: assert property (p_tdo_quiet)
        else $error("Readout data moved while readout idle");
    a_status_brk: assert property (p_status_brk)
        else $error("Status break bit differs from break request");
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read returned data");
endmodule : dttu_props
`default_nettype wire

// >>> dttu_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none
module dttu_jtag_host (
    // Readout pins.
    output logic        tck,
    output logic        shift,
    input  wire logic   tdo
);
    // The readout clock stands still between frames.
    initial
    begin
        tck   = 1'b0;
        shift = 1'b0;
    end

    // Pull one frame out, bit 0 first; the clock runs at an eighth of the system clock.
    task get(output logic [65:0] f);
        shift <= 1'b1;
        #64;
        f[0] = tdo;
        for (int i = 1; i < 66; i++)
        begin
            tck <= 1'b1;
            #32;
            tck <= 1'b0;
            #32;
            f[i] = tdo;
        end
        shift <= 1'b0;
        #64;
    endtask : get
endmodule : dttu_jtag_host
`default_nettype wire

// >>> dttu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dttu_top_tb;
    import dttu_pkg::*;
    logic        MCLK, RST, REG_WR, REG_RD, I_VALID, I_FLOW, D_VALID, D_WRITE;
    logic        BREAK_REQ, EXT_TRIG, JTAG_TCK, JTAG_SHIFT, JTAG_TDO;
    logic [7:0]  REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, I_ADDR, D_ADDR, D_DATA, r;
    logic [65:0] f;
    int          n_mismatch, num_checks;

    // System clock.
    initial
    begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end

    dttu_top u_dut (.MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .I_VALID(I_VALID),
        .I_ADDR(I_ADDR), .I_FLOW(I_FLOW), .D_VALID(D_VALID), .D_WRITE(D_WRITE),
        .D_ADDR(D_ADDR), .D_DATA(D_DATA), .BREAK_REQ(BREAK_REQ), .EXT_TRIG(EXT_TRIG),
        .JTAG_TCK(JTAG_TCK), .JTAG_SHIFT(JTAG_SHIFT), .JTAG_TDO(JTAG_TDO));
    dttu_jtag_host u_host (.tck(JTAG_TCK), .shift(JTAG_SHIFT), .tdo(JTAG_TDO));

    ////////////////////////////////////////
    // Comparison, bus cycles and the verdict.
    task chk(input string nm, input logic [65:0] seen, input logic [65:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge MCLK);
        REG_RD <= 1'b1; REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1 r = REG_RDATA;
    endtask : rd
    // One transfer cycle; address and data lines show the inverse once released.
    task bus(input logic iv, input logic [31:0] ia, input logic fl, input logic dv,
             input logic dw, input logic [31:0] da, input logic [31:0] dd);
        @(posedge MCLK);
        I_VALID <= iv; I_ADDR <= ia; I_FLOW <= fl;
        D_VALID <= dv; D_WRITE <= dw; D_ADDR <= da; D_DATA <= dd;
        @(posedge MCLK);
        I_VALID <= 1'b0; D_VALID <= 1'b0; I_ADDR <= ~ia; D_ADDR <= ~da; D_DATA <= ~dd;
        #1;
    endtask : bus
    task stop_test;
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////
    // Scenarios.
    task t_regs;
        rd(OFS_CTRL);  chk("ctrl", r, 32'h68);
        rd(OFS_STATUS); chk("status", r, 32'h0);
        rd(8'hFC);     chk("unmapped", r, 32'h0);
    endtask : t_regs
    task t_break;
        wr(8'h40, 32'h100); wr(8'h48, 32'h105);
        bus(1, 32'h104, 0, 0, 0, 0, 0); chk("brk miss", BREAK_REQ, 0);
        bus(1, 32'h100, 0, 0, 0, 0, 0); chk("brk hit", BREAK_REQ, 1);
        rd(OFS_STATUS); chk("st brk", r[ST_BREAK], 1);
        wr(OFS_CTRL, 32'h268);
        #1 chk("brk rel", BREAK_REQ, 0);
    endtask : t_break
    task t_ext;
        wr(8'h50, 32'h200); wr(8'h58, 32'h227);
        bus(0, 0, 0, 1, 0, 32'h200, 0); chk("ext rd", EXT_TRIG, 0);
        bus(0, 0, 0, 1, 1, 32'h200, 0); chk("ext wr", EXT_TRIG, 1);
        @(posedge MCLK);
        #1 chk("ext once", EXT_TRIG, 0);
        bus(0, 0, 0, 1, 1, 32'h204, 0); chk("ext addr", EXT_TRIG, 0);
    endtask : t_ext
    task t_arm;
        wr(8'h64, 32'hAA); wr(8'h68, 32'h24B); wr(8'h40, 32'h300); wr(8'h48, 32'h2005);
        bus(0, 0, 0, 1, 1, 32'h10, 32'hAA); chk("unarmed", EXT_TRIG, 0);
        bus(1, 32'h300, 0, 0, 0, 0, 0);
        rd(OFS_STATUS); chk("armed", r[ST_ARMED], 1);
        bus(0, 0, 0, 1, 1, 32'h10, 32'hAA); chk("armed hit", EXT_TRIG, 1);
    endtask : t_arm
    task t_trace;
        wr(OFS_CTRL, 32'h69);
        bus(1, 32'h4FC, 0, 0, 0, 0, 0);
        bus(1, 32'h500, 1, 1, 1, 32'h44, 32'h55);
        wr(OFS_CTRL, 32'h6A);
        u_host.get(f); chk("exec frame", f[65:32], {2'd1, 32'h500});
        chk("exec count", f[15:0], 16'h0002);
        u_host.get(f); chk("data frame", f, {2'd3, 32'h44, 32'h55});
        u_host.get(f); chk("empty", f, 66'h0);
    endtask : t_trace
    // Range bounds from the last trigger and the first, sampling only.
    task t_range;
        wr(OFS_CTRL, 32'h78);
        wr(8'h70, 32'h280);
        wr(8'h78, 32'h1087);
        bus(0, 0, 0, 1, 0, 32'h27C, 32'h11);
        bus(0, 0, 0, 1, 1, 32'h300, 32'h12);
        bus(0, 0, 0, 1, 0, 32'h301, 32'h13);
        bus(0, 0, 0, 1, 0, 32'h280, 32'h14);
        rd(OFS_STATUS);
        chk("range count", r[ST_COUNT_LSB +: 5], 5'h02);
        u_host.get(f);
        chk("sample high", f, {2'h3, 32'h300, 32'h12});
        u_host.get(f);
        chk("sample low", f, {2'h2, 32'h280, 32'h14});
    endtask : t_range
    // Trigger-driven and manual capture, then stop on a full buffer.
    task t_flow;
        wr(OFS_CTRL, 32'h04);
        wr(8'h70, 32'h400);
        wr(8'h78, 32'h407);
        wr(8'h58, 32'hA27);
        bus(0, 0, 0, 1, 1, 32'h400, 32'h0);
        bus(0, 0, 0, 1, 0, 32'h10, 32'h77);
        bus(0, 0, 0, 1, 1, 32'h200, 32'h0);
        bus(0, 0, 0, 1, 0, 32'h20, 32'h77);
        rd(OFS_STATUS);
        chk("trig trace", r[ST_COUNT_LSB +: 5], 5'h01);
        chk("trig off", r[ST_TRACE_ON], 1'b0);
        wr(OFS_CTRL, 32'h05);
        for (int k = 0; k < 17; k++)
        begin
            bus(0, 0, 0, 1, 0, 32'h1000 + k, 32'h77);
        end
        rd(OFS_STATUS);
        chk("full flags", r[3:0], 4'hA);
        chk("full count", r[ST_COUNT_LSB +: 5], 5'h10);
        u_host.get(f);
        chk("load addr only", f, {2'h2, 32'h10, 32'h0});
    endtask : t_flow

    // Main sequence after reset.
    initial
    begin
        RST = 1'b1; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 8'h00; REG_WDATA = 32'h0;
        I_VALID = 1'b0; I_FLOW = 1'b0; I_ADDR = 32'h0;
        D_VALID = 1'b0; D_WRITE = 1'b0; D_ADDR = 32'h0; D_DATA = 32'h0;
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        t_regs;
        t_break;
        t_ext;
        t_arm;
        t_trace;
        t_range;
        t_flow;
        stop_test;
    end

    // Watchdog against a hang.
    initial
    begin
        repeat (20000) @(posedge MCLK);
        n_mismatch++;
        stop_test;
    end
endmodule : dttu_top_tb

bind dttu_top dttu_props u_props (.MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .I_VALID(I_VALID), .D_VALID(D_VALID), .BREAK_REQ(BREAK_REQ), .EXT_TRIG(EXT_TRIG),
    .JTAG_SHIFT(JTAG_SHIFT), .JTAG_TDO(JTAG_TDO));
`default_nettype wire
